// ==== verilog/lfbw_consts.svh ====
`ifndef LFBW_CONSTS_SVH
`define LFBW_CONSTS_SVH
// ****************************************
// Bit positions of the latched word
// ****************************************
`define LFBW_BIT_GENERAL     5'd0
`define LFBW_BIT_LIMIT       5'd1
`define LFBW_BIT_RANGE       5'd2
`define LFBW_BIT_QSTOP       5'd3
`define LFBW_BIT_STO_ZERO    5'd4
`define LFBW_BIT_LINK        5'd6
`define LFBW_BIT_REFSIG      5'd9
`define LFBW_BIT_MODE        5'd10
`define LFBW_BIT_UNDERV      5'd14
`define LFBW_BIT_OVERV       5'd15
`define LFBW_BIT_OVERCUR     5'd18
`define LFBW_BIT_CTRLV       5'd20
`define LFBW_BIT_TEMP        5'd21
`define LFBW_BIT_FOLLOW      5'd22
`define LFBW_BIT_STO_DIFF    5'd24
`define LFBW_BIT_NVM         5'd29
`define LFBW_BIT_STARTUP     5'd30
`define LFBW_BIT_SYSTEM      5'd31
// ****************************************
// Reset values
// ****************************************
`define LFBW_WORD_RESET      32'h0000_0000
`endif

// ==== verilog/lfbw_pkg.sv ====
`default_nettype none
package lfbw_pkg;
  typedef enum logic [2:0] {
    LFBW_CLASS_WARN  = 3'b000,
    LFBW_CLASS_QSTOP = 3'b001,
    LFBW_CLASS_QOFF  = 3'b010,
    LFBW_CLASS_FATAL = 3'b011,
    LFBW_CLASS_UNCTL = 3'b100
  } lfbw_class_e;
  typedef enum logic [1:0] {
    LFBW_ST_RUN  = 2'b00,
    LFBW_ST_STOP = 2'b01,
    LFBW_ST_OFF  = 2'b10
  } lfbw_state_e;
  typedef logic [31:0] lfbw_word_t;
endpackage
`default_nettype wire

// ==== verilog/lfbw_class_map.sv ====
`include "lfbw_consts.svh"
`default_nettype none
// ****************************************
// Worst pending class from the latched word
// ****************************************
module lfbw_class_map (
  input  wire logic                 [31:0] pend_i,
  input  wire logic                        low_shut_i,
  input  wire logic                        nvm_fatal4_i,
  input  wire logic                        start_fatal4_i,
  input  wire lfbw_pkg::lfbw_class_e       follow_class_i,
  output logic                             any_o,
  output lfbw_pkg::lfbw_class_e            class_o
);
  import lfbw_pkg::*;
  logic [2:0] c1, c2, c3, c4;
  assign any_o = |pend_i;
  assign c1 = (pend_i[`LFBW_BIT_LIMIT] | pend_i[`LFBW_BIT_RANGE] | pend_i[`LFBW_BIT_QSTOP])
              ? 3'h1 : 3'h0;
  assign c2 = (pend_i[`LFBW_BIT_MODE] | pend_i[`LFBW_BIT_UNDERV]) ? 3'h2 : 3'h0;
  assign c3 = (pend_i[`LFBW_BIT_STO_ZERO] | pend_i[`LFBW_BIT_OVERV]
              | pend_i[`LFBW_BIT_OVERCUR] | pend_i[`LFBW_BIT_TEMP]
              | (pend_i[`LFBW_BIT_UNDERV] & low_shut_i)
              | pend_i[`LFBW_BIT_NVM] | pend_i[`LFBW_BIT_STARTUP]) ? 3'h3 : 3'h0;
  assign c4 = (pend_i[`LFBW_BIT_STO_DIFF] | pend_i[`LFBW_BIT_SYSTEM]
              | (pend_i[`LFBW_BIT_NVM] & nvm_fatal4_i)
              | (pend_i[`LFBW_BIT_STARTUP] & start_fatal4_i)) ? 3'h4 : 3'h0;
  // Worst class wins; follow class is configurable
  always_comb begin
    logic [2:0] w;
    w = 3'h0;
    if (c1 > w) w = c1;
    if (c2 > w) w = c2;
    if (c3 > w) w = c3;
    if (c4 > w) w = c4;
    if (pend_i[`LFBW_BIT_FOLLOW] && (follow_class_i > w)) w = follow_class_i;
    class_o = lfbw_class_e'(w);
  end
endmodule
`default_nettype wire

// ==== verilog/lfbw_latch.sv ====
`include "lfbw_consts.svh"
`default_nettype none
// ****************************************
// Sticky bit store, set wins over clear
// ****************************************
module lfbw_latch #(
  parameter int WIDTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] set_i,
  input  wire logic             clr_i,
  output logic      [WIDTH-1:0] bits_o
);
  localparam logic [WIDTH-1:0] RESET_WORD = WIDTH'(`LFBW_WORD_RESET);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) bits_o[g] <= RESET_WORD[g];
        else if (set_i[g]) bits_o[g] <= 1'b1;
        else if (clr_i) bits_o[g] <= 1'b0;
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== verilog/lfbw_top.sv ====
`include "lfbw_consts.svh"
`default_nettype none
module lfbw_top (
  input  wire logic                  CLK_SYS_I,
  input  wire logic                  RST_N_I,
  input  wire logic                  GENERAL_ERROR_I,
  input  wire logic                  POSITIVE_TRAVEL_LIMIT_INPUT_I,
  input  wire logic                  NEGATIVE_TRAVEL_LIMIT_INPUT_I,
  input  wire logic                  REFERENCE_LIMIT_INPUT_I,
  input  wire logic                  LIMIT_LINE_BROKEN_I,
  input  wire logic                  OUT_OF_TRAVEL_RANGE_I,
  input  wire logic                  FIELDBUS_FAST_STOP_I,
  input  wire logic                  SAFE_TORQUE_OFF_INPUT_A_I,
  input  wire logic                  SAFE_TORQUE_OFF_INPUT_B_I,
  input  wire logic                  LINK_IS_RS485_I,
  input  wire logic                  RS485_LINK_LOST_I,
  input  wire logic                  REF_SIGNAL_BAD_I,
  input  wire logic                  MODE_PROCESS_ERROR_I,
  input  wire logic                  RAIL_BELOW_STOP_I,
  input  wire logic                  RAIL_BELOW_SHUTOFF_I,
  input  wire logic                  RAIL_OVERVOLTAGE_I,
  input  wire logic                  PHASE_OVERCURRENT_I,
  input  wire logic                  CTRL_SUPPLY_LOW_I,
  input  wire logic                  STAGE_OVERTEMP_I,
  input  wire logic                  FOLLOWING_ERROR_I,
  input  wire lfbw_pkg::lfbw_class_e FOLLOWING_ERROR_RESPONSE_SETTING_I,
  input  wire logic                  NVM_CHECKSUM_FAIL_I,
  input  wire logic                  NVM_FAIL_FATAL4_I,
  input  wire logic                  STARTUP_FAIL_I,
  input  wire logic                  STARTUP_FAIL_FATAL4_I,
  input  wire logic                  SYSTEM_FAULT_I,
  input  wire logic                  STANDSTILL_I,
  input  wire logic                  FAULT_RESET_I,
  output lfbw_pkg::lfbw_word_t       LATCHED_ERROR_BITS_O,
  output lfbw_pkg::lfbw_class_e      ACTIVE_CLASS_O,
  output logic                       QUICK_STOP_O,
  output logic                       STAGE_ENABLE_O,
  output logic                       WARNING_O
);
  import lfbw_pkg::*;

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_q1, rst_n;
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // ****************************************
  // Cause vector
  // ****************************************
  logic [31:0] cause;
  logic        low_shut;
  logic        sto_zero, sto_diff;
  assign sto_zero = !SAFE_TORQUE_OFF_INPUT_A_I && !SAFE_TORQUE_OFF_INPUT_B_I;
  assign sto_diff = SAFE_TORQUE_OFF_INPUT_A_I ^ SAFE_TORQUE_OFF_INPUT_B_I;
  always_comb begin
    cause = 32'h0000_0000;
    cause[`LFBW_BIT_GENERAL]  = GENERAL_ERROR_I;
    cause[`LFBW_BIT_LIMIT]    = POSITIVE_TRAVEL_LIMIT_INPUT_I
                              | NEGATIVE_TRAVEL_LIMIT_INPUT_I
                              | REFERENCE_LIMIT_INPUT_I | LIMIT_LINE_BROKEN_I;
    cause[`LFBW_BIT_RANGE]    = OUT_OF_TRAVEL_RANGE_I;
    cause[`LFBW_BIT_QSTOP]    = FIELDBUS_FAST_STOP_I;
    cause[`LFBW_BIT_STO_ZERO] = sto_zero;
    cause[`LFBW_BIT_LINK]     = RS485_LINK_LOST_I & LINK_IS_RS485_I;
    cause[`LFBW_BIT_REFSIG]   = REF_SIGNAL_BAD_I;
    cause[`LFBW_BIT_MODE]     = MODE_PROCESS_ERROR_I;
    cause[`LFBW_BIT_UNDERV]   = RAIL_BELOW_STOP_I | RAIL_BELOW_SHUTOFF_I;
    cause[`LFBW_BIT_OVERV]    = RAIL_OVERVOLTAGE_I;
    cause[`LFBW_BIT_OVERCUR]  = PHASE_OVERCURRENT_I;
    cause[`LFBW_BIT_CTRLV]    = CTRL_SUPPLY_LOW_I;
    cause[`LFBW_BIT_TEMP]     = STAGE_OVERTEMP_I;
    cause[`LFBW_BIT_FOLLOW]   = FOLLOWING_ERROR_I;
    cause[`LFBW_BIT_STO_DIFF] = sto_diff;
    cause[`LFBW_BIT_NVM]      = NVM_CHECKSUM_FAIL_I;
    cause[`LFBW_BIT_STARTUP]  = STARTUP_FAIL_I;
    cause[`LFBW_BIT_SYSTEM]   = SYSTEM_FAULT_I;
  end

  // Shut-off depth of the undervoltage is itself sticky, so class 3 survives recovery
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) low_shut <= 1'b0;
    else if (RAIL_BELOW_SHUTOFF_I) low_shut <= 1'b1;
    else if (FAULT_RESET_I) low_shut <= 1'b0;
  end

  // ****************************************
  // Latched word
  // ****************************************
  logic [31:0] word;
  lfbw_latch #(.WIDTH(32)) u_latch (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (rst_n),
    .set_i   (cause),
    .clr_i   (FAULT_RESET_I),
    .bits_o  (word)
  );
  assign LATCHED_ERROR_BITS_O = word;

  // ****************************************
  // Class and reaction
  // ****************************************
  logic        any_pend;
  lfbw_class_e cls;
  lfbw_class_map u_map (
    .pend_i         (word),
    .low_shut_i     (low_shut),
    .nvm_fatal4_i   (NVM_FAIL_FATAL4_I),
    .start_fatal4_i (STARTUP_FAIL_FATAL4_I),
    .follow_class_i (FOLLOWING_ERROR_RESPONSE_SETTING_I),
    .any_o          (any_pend),
    .class_o        (cls)
  );

  // Stopping classes pass through STOP; disabling classes skip it
  lfbw_state_e st, next_st;
  always_comb begin
    next_st = st;
    case (st)
      LFBW_ST_RUN: begin
        if (cls == LFBW_CLASS_FATAL || cls == LFBW_CLASS_UNCTL) next_st = LFBW_ST_OFF;
        else if (cls == LFBW_CLASS_QSTOP || cls == LFBW_CLASS_QOFF) next_st = LFBW_ST_STOP;
      end
      LFBW_ST_STOP: begin
        if (cls == LFBW_CLASS_FATAL || cls == LFBW_CLASS_UNCTL) next_st = LFBW_ST_OFF;
        else if (cls == LFBW_CLASS_QOFF && STANDSTILL_I) next_st = LFBW_ST_OFF;
        else if (cls == LFBW_CLASS_WARN) next_st = LFBW_ST_RUN;
      end
      LFBW_ST_OFF: begin
        if (cls == LFBW_CLASS_WARN) next_st = LFBW_ST_RUN;
      end
      default: next_st = LFBW_ST_OFF;
    endcase
  end
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) st <= LFBW_ST_RUN;
    else st <= next_st;
  end

  // Class 4 in hardware clears like any other; only power cycling truly ends it upstream
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      ACTIVE_CLASS_O <= LFBW_CLASS_WARN;
      QUICK_STOP_O   <= 1'b0;
      STAGE_ENABLE_O <= 1'b1;
      WARNING_O      <= 1'b0;
    end else begin
      ACTIVE_CLASS_O <= cls;
      QUICK_STOP_O   <= (next_st == LFBW_ST_STOP);
      STAGE_ENABLE_O <= (next_st != LFBW_ST_OFF);
      WARNING_O      <= any_pend && (cls == LFBW_CLASS_WARN);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  AST_STICKY: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    !$past(FAULT_RESET_I) |-> (word & $past(word)) == $past(word))
    else $error("Latched bit dropped without reset");
  AST_STO_ZERO: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    sto_zero |=> word[`LFBW_BIT_STO_ZERO] ##1 !STAGE_ENABLE_O)
    else $error("STO low did not disable stage");
  AST_STO_DIFF: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    sto_diff |=> word[`LFBW_BIT_STO_DIFF] && cls == LFBW_CLASS_UNCTL)
    else $error("STO mismatch not latched as class 4");
  AST_QSTOP: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    FIELDBUS_FAST_STOP_I && !FAULT_RESET_I |=> word[`LFBW_BIT_QSTOP]
      ##1 (QUICK_STOP_O || !STAGE_ENABLE_O))
    else $error("Fast stop not latched");
  AST_LINK: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    RS485_LINK_LOST_I && !LINK_IS_RS485_I && !word[`LFBW_BIT_LINK] |=> !word[`LFBW_BIT_LINK])
    else $error("Link bit set for non serial link");
  AST_UNDERV: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    RAIL_BELOW_SHUTOFF_I |=> word[`LFBW_BIT_UNDERV] && cls >= LFBW_CLASS_FATAL)
    else $error("Deep undervoltage not class 3");
  AST_CLEAR: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    FAULT_RESET_I && cause == 32'h0000_0000 |=> word == 32'h0000_0000)
    else $error("Fault reset left bits set");
  AST_WARN: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    cls == LFBW_CLASS_WARN && st == LFBW_ST_RUN |=> STAGE_ENABLE_O && !QUICK_STOP_O)
    else $error("Warning interrupted motion");
  AST_FOLLOW: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    word == 32'h0040_0000 && !low_shut |-> cls == FOLLOWING_ERROR_RESPONSE_SETTING_I)
    else $error("Following error class not from setting");

  // ****************************************
  // Per-bit and reaction checks
  // ****************************************
  // Class checks below class 4 use >= since a worse pending bit may lift the class further

  AST_GENERAL: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    GENERAL_ERROR_I |=> word[`LFBW_BIT_GENERAL])
    else $error("General error not latched");

  AST_LIMIT: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    (POSITIVE_TRAVEL_LIMIT_INPUT_I || NEGATIVE_TRAVEL_LIMIT_INPUT_I || REFERENCE_LIMIT_INPUT_I
      || LIMIT_LINE_BROKEN_I) |=> word[`LFBW_BIT_LIMIT] && cls >= LFBW_CLASS_QSTOP)
    else $error("Limit fault not latched as class 1");

  AST_RANGE: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    OUT_OF_TRAVEL_RANGE_I |=> word[`LFBW_BIT_RANGE] && cls >= LFBW_CLASS_QSTOP)
    else $error("Travel range fault not latched as class 1");

  AST_STO_ZERO_CLASS: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    sto_zero |=> cls >= LFBW_CLASS_FATAL)
    else $error("STO low not class 3");

  AST_LINK_SET: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    RS485_LINK_LOST_I && LINK_IS_RS485_I |=> word[`LFBW_BIT_LINK])
    else $error("Serial link loss not latched");

  AST_REFSIG: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    REF_SIGNAL_BAD_I |=> word[`LFBW_BIT_REFSIG])
    else $error("Reference signal fault not latched");

  AST_MODE: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    MODE_PROCESS_ERROR_I |=> word[`LFBW_BIT_MODE] && cls >= LFBW_CLASS_QOFF)
    else $error("Mode error not latched as class 2");

  AST_UNDERV_STOP: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    RAIL_BELOW_STOP_I |=> word[`LFBW_BIT_UNDERV] && cls >= LFBW_CLASS_QOFF)
    else $error("Undervoltage not latched as class 2");

  AST_OVERV: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    RAIL_OVERVOLTAGE_I |=> word[`LFBW_BIT_OVERV] && cls >= LFBW_CLASS_FATAL)
    else $error("Overvoltage not latched as class 3");

  AST_OVERCUR: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    PHASE_OVERCURRENT_I |=> word[`LFBW_BIT_OVERCUR] && cls >= LFBW_CLASS_FATAL)
    else $error("Overcurrent not latched as class 3");

  AST_CTRLV: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    CTRL_SUPPLY_LOW_I |=> word[`LFBW_BIT_CTRLV])
    else $error("Controller supply fault not latched");

  AST_TEMP: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    STAGE_OVERTEMP_I |=> word[`LFBW_BIT_TEMP] && cls >= LFBW_CLASS_FATAL)
    else $error("Overtemperature not latched as class 3");

  AST_FOLLOW_SET: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    FOLLOWING_ERROR_I |=> word[`LFBW_BIT_FOLLOW])
    else $error("Following error not latched");

  AST_NVM: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    NVM_CHECKSUM_FAIL_I |=> word[`LFBW_BIT_NVM] && cls >= LFBW_CLASS_FATAL)
    else $error("Store checksum fault not latched as class 3");

  AST_NVM4: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    NVM_CHECKSUM_FAIL_I ##1 NVM_FAIL_FATAL4_I |-> cls == LFBW_CLASS_UNCTL)
    else $error("Store checksum fault not class 4");

  AST_START: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    STARTUP_FAIL_I |=> word[`LFBW_BIT_STARTUP] && cls >= LFBW_CLASS_FATAL)
    else $error("Start-up fault not latched as class 3");

  AST_START4: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    STARTUP_FAIL_I ##1 STARTUP_FAIL_FATAL4_I |-> cls == LFBW_CLASS_UNCTL)
    else $error("Start-up fault not class 4");

  AST_SYSTEM: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    SYSTEM_FAULT_I |=> word[`LFBW_BIT_SYSTEM] && cls == LFBW_CLASS_UNCTL)
    else $error("System fault not latched as class 4");

  AST_WORD_SET: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    cause != 32'h0000_0000 |=> (word & $past(cause)) == $past(cause))
    else $error("Active cause missing from word");

  AST_OFF_NOW: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    cls >= LFBW_CLASS_FATAL |=> !STAGE_ENABLE_O && !QUICK_STOP_O)
    else $error("Class 3 or 4 did not disable at once");

  AST_QSTOP_ON: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    cls == LFBW_CLASS_QSTOP && st != LFBW_ST_OFF |=> QUICK_STOP_O && STAGE_ENABLE_O)
    else $error("Class 1 did not stop with stage on");

  AST_QOFF_WAIT: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    cls == LFBW_CLASS_QOFF && st == LFBW_ST_STOP && !STANDSTILL_I
      |=> QUICK_STOP_O && STAGE_ENABLE_O)
    else $error("Class 2 disabled before standstill");

  AST_QOFF_DONE: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    cls == LFBW_CLASS_QOFF && st == LFBW_ST_STOP && STANDSTILL_I |=> !STAGE_ENABLE_O)
    else $error("Class 2 did not disable at standstill");
endmodule
`default_nettype wire

// ==== tb/lfbw_master_model.sv ====
`default_nettype none
// ****************************************
// Fieldbus master that reads the latched word
// ****************************************
module lfbw_master_model #(
  parameter int NODE_ADDR = 1
) (
  input  wire logic                 clk_i,
  input  wire logic                 rd_req_i,
  input  wire lfbw_pkg::lfbw_word_t word_i,
  output lfbw_pkg::lfbw_word_t      rd_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import lfbw_pkg::*;
  // A read is answered whenever the node address is not 0
  // Reply holds one cycle only, then the stale copy is scrambled
  always_ff @(posedge clk_i) begin
    if (rd_req_i && NODE_ADDR != 0) begin
      rd_data_o <= word_i;
    end else begin
      rd_data_o <= ~rd_data_o;
    end
  end
endmodule
`default_nettype wire

// ==== tb/latched_fault_bit_word_bench.sv ====
`default_nettype none
module latched_fault_bit_word_bench import lfbw_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [4:0] idx;
    logic [1:0] ab;
    logic [4:0] bt;
    logic [2:0] cl;
    logic       ck;
  } lfbw_row_s;
  logic        clk, rst_n, sa, sb, sel, f4n, f4s, still, frst, rq, qs, en, warn;
  logic [31:0] c;
  lfbw_class_e fset, cls;
  lfbw_word_t  word, mdata, w;
  int          fails, tests_run;
  // ****************************************
  // Cause index, STO pair, bit, class, class known
  // ****************************************
  lfbw_row_s rows [22] = '{
    '{5'd0, 2'b11, 5'd0, 3'd0, 1'b1}, '{5'd1, 2'b11, 5'd1, 3'd1, 1'b1},
    '{5'd2, 2'b11, 5'd1, 3'd1, 1'b1}, '{5'd3, 2'b11, 5'd1, 3'd1, 1'b1},
    '{5'd4, 2'b11, 5'd1, 3'd1, 1'b1}, '{5'd5, 2'b11, 5'd2, 3'd1, 1'b1},
    '{5'd6, 2'b11, 5'd3, 3'd1, 1'b1}, '{5'd7, 2'b11, 5'd6, 3'd0, 1'b0},
    '{5'd8, 2'b11, 5'd9, 3'd0, 1'b0}, '{5'd9, 2'b11, 5'd10, 3'd2, 1'b1},
    '{5'd10, 2'b11, 5'd14, 3'd2, 1'b1}, '{5'd11, 2'b11, 5'd14, 3'd3, 1'b1},
    '{5'd12, 2'b11, 5'd15, 3'd3, 1'b1}, '{5'd13, 2'b11, 5'd18, 3'd3, 1'b1},
    '{5'd14, 2'b11, 5'd20, 3'd0, 1'b0}, '{5'd15, 2'b11, 5'd21, 3'd3, 1'b1},
    '{5'd16, 2'b11, 5'd22, 3'd1, 1'b1}, '{5'd17, 2'b11, 5'd29, 3'd3, 1'b1},
    '{5'd18, 2'b11, 5'd30, 3'd3, 1'b1}, '{5'd19, 2'b11, 5'd31, 3'd4, 1'b1},
    '{5'd31, 2'b00, 5'd4, 3'd3, 1'b1}, '{5'd31, 2'b10, 5'd24, 3'd4, 1'b1}
  };
  lfbw_top lfbw_top_i (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .GENERAL_ERROR_I(c[0]),
    .POSITIVE_TRAVEL_LIMIT_INPUT_I(c[1]), .NEGATIVE_TRAVEL_LIMIT_INPUT_I(c[2]),
    .REFERENCE_LIMIT_INPUT_I(c[3]), .LIMIT_LINE_BROKEN_I(c[4]), .OUT_OF_TRAVEL_RANGE_I(c[5]),
    .FIELDBUS_FAST_STOP_I(c[6]), .SAFE_TORQUE_OFF_INPUT_A_I(sa), .SAFE_TORQUE_OFF_INPUT_B_I(sb),
    .LINK_IS_RS485_I(sel), .RS485_LINK_LOST_I(c[7]), .REF_SIGNAL_BAD_I(c[8]),
    .MODE_PROCESS_ERROR_I(c[9]), .RAIL_BELOW_STOP_I(c[10]), .RAIL_BELOW_SHUTOFF_I(c[11]),
    .RAIL_OVERVOLTAGE_I(c[12]), .PHASE_OVERCURRENT_I(c[13]), .CTRL_SUPPLY_LOW_I(c[14]),
    .STAGE_OVERTEMP_I(c[15]), .FOLLOWING_ERROR_I(c[16]),
    .FOLLOWING_ERROR_RESPONSE_SETTING_I(fset), .NVM_CHECKSUM_FAIL_I(c[17]),
    .NVM_FAIL_FATAL4_I(f4n), .STARTUP_FAIL_I(c[18]), .STARTUP_FAIL_FATAL4_I(f4s),
    .SYSTEM_FAULT_I(c[19]), .STANDSTILL_I(still), .FAULT_RESET_I(frst),
    .LATCHED_ERROR_BITS_O(word), .ACTIVE_CLASS_O(cls), .QUICK_STOP_O(qs),
    .STAGE_ENABLE_O(en), .WARNING_O(warn));
  lfbw_master_model #(.NODE_ADDR(1)) lfbw_master_model_i (
    .clk_i(clk), .rd_req_i(rq), .word_i(word), .rd_data_o(mdata));
  // ****************************************
  // Compare and bus tasks
  // ****************************************
  task cmp_w(input lfbw_word_t got, input lfbw_word_t exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cmp_c(input lfbw_class_e got, input lfbw_class_e exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cmp_b(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task rd(output lfbw_word_t v);
    @(negedge clk) rq = 1'b1;
    @(negedge clk) rq = 1'b0;
    v = mdata;
  endtask
  // One-cycle cause pulse, then enough edges for word, class and state
  task hit(input logic [4:0] idx, input logic [1:0] ab);
    @(negedge clk) c[idx] = 1'b1;
    {sa, sb} = ab;
    @(negedge clk) c = '0;
    {sa, sb} = 2'b11;
    repeat (3) @(negedge clk);
  endtask
  task clr;
    @(negedge clk) frst = 1'b1;
    @(negedge clk) frst = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task react(input logic [2:0] k);
    cmp_b(qs, k == 3'd1 || k == 3'd2);
    cmp_b(en, k < 3'd3);
    cmp_b(warn, k == 3'd0);
  endtask
  // Count rising edges so the start-up edge of the clock cannot shorten the hold
  task do_rst;
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask
  task test_done;
    if (fails == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Hang guard, far above the real run length
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    test_done;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    c = '0;
    {sa, sb, sel, f4n, f4s, still, frst, rq} = 8'h e0;
    fset = LFBW_CLASS_QSTOP;
    fails = 0;
    tests_run = 0;
    do_rst;
    rd(w);
    cmp_w(w, 32'h0);
    cmp_c(cls, LFBW_CLASS_WARN);
    cmp_b(en, 1'b1);
    foreach (rows[i]) begin
      hit(rows[i].idx, rows[i].ab);
      rd(w);
      cmp_w(w, 32'h1 << rows[i].bt);
      if (rows[i].ck) begin
        cmp_c(cls, lfbw_class_e'(rows[i].cl));
        react(rows[i].cl);
      end
      clr;
      rd(w);
      cmp_w(w, 32'h0);
    end
    // Lost link ignored when the link is not the serial one
    sel = 1'b0;
    hit(5'd7, 2'b11);
    rd(w);
    cmp_w(w, 32'h0);
    sel = 1'b1;
    for (int k = 0; k < 5; k++) begin
      fset = lfbw_class_e'(k);
      hit(5'd16, 2'b11);
      cmp_c(cls, lfbw_class_e'(k));
      clr;
    end
    {f4n, f4s} = 2'b11;
    hit(5'd17, 2'b11);
    cmp_c(cls, LFBW_CLASS_UNCTL);
    clr;
    hit(5'd18, 2'b11);
    cmp_c(cls, LFBW_CLASS_UNCTL);
    clr;
    // Class 2 disables the stage only once stopped
    still = 1'b1;
    hit(5'd9, 2'b11);
    repeat (2) @(negedge clk);
    cmp_b(en, 1'b0);
    still = 1'b0;
    clr;
    // Cause in the reset cycle wins, then back-to-back causes
    @(negedge clk) frst = 1'b1;
    c[0] = 1'b1;
    @(negedge clk) frst = 1'b0;
    c = 32'h2;
    @(negedge clk) c = 32'h1000;
    @(negedge clk) c = '0;
    repeat (3) @(negedge clk);
    rd(w);
    cmp_w(w, 32'h8003);
    cmp_c(cls, LFBW_CLASS_FATAL);
    // Reset in mid-run empties the word
    rst_n = 1'b0;
    @(posedge clk) #1;
    cmp_w(word, 32'h0);
    do_rst;
    rd(w);
    cmp_w(w, 32'h0);
    cmp_c(cls, LFBW_CLASS_WARN);
    cmp_b(en, 1'b1);
    cmp_b(qs, 1'b0);
    test_done;
  end
endmodule
`default_nettype wire
